// >>> core/adcm_pkg.sv
package adcm_pkg;

  localparam int unsigned CLK_PERIOD_NS      = 40;
  // Conversion clock period, a fixed constant; HALF_CYCLES derives from it and the system clock
  localparam int unsigned CONV_CLK_PERIOD_NS = 4000;
  localparam int unsigned HALF_CYCLES        =
    ((CONV_CLK_PERIOD_NS / 2) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CONV_TIME_MAX_US   = 40;
  localparam int unsigned CONV_MAX_CYCLES    = (CONV_TIME_MAX_US * 1000) / CLK_PERIOD_NS;

  localparam int unsigned MUX_TOP_POS = 4;
  localparam int unsigned MUX_CFG_POS = 3;
  localparam int unsigned SYNC_W      = 13;
  localparam int unsigned SYNC_CS_POS = 12;
  localparam int unsigned SYNC_WR_POS = 11;
  localparam int unsigned SYNC_RD_POS = 10;
  localparam int unsigned SYNC_CMP_POS = 9;
  localparam int unsigned SYNC_VAR_POS = 8;

  localparam logic [12:0] SYNC_RST     = 13'h1c00;
  localparam logic [4:0]  MUX_ADDR_RST = 5'h08;
  localparam logic [7:0]  RESULT_RST   = 8'h00;
  localparam logic [7:0]  SAR_MSB      = 8'h80;
  localparam logic [7:0]  PS_NEG_EIGHT = 8'h80;
  localparam logic [7:0]  PS_NEG_FOUR  = 8'h08;

  typedef enum logic [2:0] {
    MODE_DIFF   = 3'b001,
    MODE_SINGLE = 3'b010,
    MODE_PSEUDO = 3'b100
  } adcm_mode_t;

  typedef enum logic [2:0] {
    SEQ_IDLE   = 3'b001,
    SEQ_SAMPLE = 3'b010,
    SEQ_BITS   = 3'b100
  } adcm_seq_state_t;

  function automatic logic [7:0] chan_onehot(input logic [2:0] idx);
    chan_onehot = 8'h01 << idx;
  endfunction

endpackage

// >>> core/adcm_conv_if.sv
`timescale 1ns/1ps
`default_nettype none
interface adcm_conv_if;
  logic       start;
  logic       abort;
  logic       busy;
  logic       done;
  logic [7:0] result;
  modport ctrl (output start, output abort, input busy, input done, input result);
  modport seq  (input start, input abort, output busy, output done, output result);
endinterface
`default_nettype wire

// >>> core/adcm_mux_decode.sv
`timescale 1ns/1ps
`default_nettype none
module adcm_mux_decode (
  input  wire logic [4:0]         addr_i,
  input  wire logic               eight_i,
  output logic [7:0]              pos_sel_o,
  output logic [7:0]              neg_sel_o,
  output logic                    analog_ground_pin_sel_o,
  output adcm_pkg::adcm_mode_t    mode_o
);
  logic       mux_addr_top_bit;
  logic       mux_config_select_bit;
  logic       mux_addr_bit2;
  logic       mux_addr_bit1;
  logic       mux_addr_bit0;
  logic [2:0] diff_idx;
  logic [2:0] se_idx;
  logic [2:0] ps_idx;
  logic [7:0] eighth_analog_input;

  assign mux_addr_top_bit      = addr_i[adcm_pkg::MUX_TOP_POS];
  assign mux_config_select_bit = addr_i[adcm_pkg::MUX_CFG_POS];
  assign mux_addr_bit2         = addr_i[2];
  assign mux_addr_bit1         = addr_i[1];
  assign mux_addr_bit0         = addr_i[0];

  // Pair picked by bits 2..1 (bit 1 only on four inputs), bit 0 swaps polarity
  assign diff_idx = eight_i ? {mux_addr_bit2, mux_addr_bit1, mux_addr_bit0}  // RL6
                            : {1'b0, mux_addr_bit1, mux_addr_bit0};         // RL1 RL2
  assign se_idx   = eight_i ? addr_i[2:0] : {1'b0, mux_addr_bit1, mux_addr_bit0};
  // Common negative input cannot also be positive: last code clamps down
  assign ps_idx   = eight_i ? ((addr_i[2:0] == 3'h7) ? 3'h6 : addr_i[2:0])
                            : ((addr_i[1:0] == 2'h3) ? 3'h2 : {1'b0, addr_i[1:0]});
  assign eighth_analog_input = eight_i ? adcm_pkg::PS_NEG_EIGHT : adcm_pkg::PS_NEG_FOUR;

  assign mode_o = !mux_config_select_bit ? adcm_pkg::MODE_DIFF      // RL5
                : !mux_addr_top_bit      ? adcm_pkg::MODE_SINGLE
                :                          adcm_pkg::MODE_PSEUDO;

  assign pos_sel_o = (mode_o == adcm_pkg::MODE_DIFF)   ? adcm_pkg::chan_onehot(diff_idx)
                   : (mode_o == adcm_pkg::MODE_SINGLE) ? adcm_pkg::chan_onehot(se_idx)  // RL3 RL7
                   :                                     adcm_pkg::chan_onehot(ps_idx); // RL4 RL8
  assign neg_sel_o = (mode_o == adcm_pkg::MODE_DIFF)   ? adcm_pkg::chan_onehot(diff_idx ^ 3'h1)
                   : (mode_o == adcm_pkg::MODE_SINGLE) ? 8'h00
                   :                                     eighth_analog_input;          // RL4 RL8
  assign analog_ground_pin_sel_o = (mode_o == adcm_pkg::MODE_SINGLE);                                // RL3 RL7
endmodule
`default_nettype wire

// >>> core/adcm_sar_seq.sv
`timescale 1ns/1ps
`default_nettype none
module adcm_sar_seq #(
  parameter int unsigned HALF = adcm_pkg::HALF_CYCLES
) (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  adcm_conv_if.seq        conv,
  input  wire logic       comp_i,
  output logic [7:0]      dac_code_o,
  output logic            sample_pos_o,
  output logic            sample_neg_o,
  output logic            comp_strobe_o
);
  localparam int unsigned PERIOD = 2 * HALF;
  localparam int unsigned TW     = $clog2(PERIOD);
  localparam int HALF_I          = HALF;
  localparam int PERIOD_I        = PERIOD;

  adcm_pkg::adcm_seq_state_t state;
  logic [TW-1:0] timer;
  logic [7:0]    mask;
  logic [7:0]    next_code;
  logic          period_end;
  logic [3:0]    strobe_cnt;
  logic          comp_seen;

  assign period_end    = (timer == TW'(PERIOD - 1));
  assign sample_pos_o  = (state == adcm_pkg::SEQ_SAMPLE) && (timer == '0);       // RL11
  assign sample_neg_o  = (state == adcm_pkg::SEQ_SAMPLE) && (timer == TW'(HALF)); // RL11
  assign comp_strobe_o = (state == adcm_pkg::SEQ_BITS) && period_end;            // RL12
  // Comparator low means trial code too high, so the bit drops
  assign next_code     = (comp_i ? dac_code_o : (dac_code_o & ~mask)) | (mask >> 1); // RL13 RL15
  assign conv.busy     = (state != adcm_pkg::SEQ_IDLE);

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state       <= adcm_pkg::SEQ_IDLE;
      timer       <= '0;
      mask        <= '0;
      dac_code_o  <= adcm_pkg::RESULT_RST;
      conv.done   <= 1'b0;
      conv.result <= adcm_pkg::RESULT_RST;
    end else begin
      conv.done <= 1'b0;
      timer     <= (!conv.busy || period_end) ? '0 : timer + 1'b1;
      if (conv.abort) begin
        state <= adcm_pkg::SEQ_IDLE;
      end else if (conv.start) begin
        state      <= adcm_pkg::SEQ_SAMPLE;
        timer      <= '0;
        mask       <= '0;
        dac_code_o <= adcm_pkg::RESULT_RST;
      end else begin
        unique case (state)
          adcm_pkg::SEQ_IDLE: ;
          adcm_pkg::SEQ_SAMPLE: if (period_end) begin
            state      <= adcm_pkg::SEQ_BITS;
            mask       <= adcm_pkg::SAR_MSB;
            dac_code_o <= adcm_pkg::SAR_MSB;
          end
          adcm_pkg::SEQ_BITS: if (period_end) begin
            dac_code_o <= next_code;
            mask       <= mask >> 1;
            if (mask[0]) begin
              state       <= adcm_pkg::SEQ_IDLE;
              conv.done   <= 1'b1;
              conv.result <= next_code; // RL10
            end
          end
        endcase
      end
    end
  end

  // Checker helpers
  always_ff @(posedge clock_i) begin
    if (rst_i || conv.start) begin
      strobe_cnt <= '0;
      comp_seen  <= 1'b0;
    end else if (comp_strobe_o) begin
      strobe_cnt <= strobe_cnt + 1'b1;
      comp_seen  <= comp_seen | comp_i;
    end
  end

  property p_neg_half_later;
    @(posedge clock_i) disable iff (rst_i || conv.abort || conv.start)
      sample_pos_o |-> ##[HALF_I:HALF_I] sample_neg_o;
  endproperty
  a_neg_half_later: assert property (p_neg_half_later) else $error("negative sample not half period later"); // RL11

  property p_strobe_period;
    @(posedge clock_i) disable iff (rst_i || conv.abort || conv.start)
      comp_strobe_o && !mask[0] |-> ##[PERIOD_I:PERIOD_I] comp_strobe_o;
  endproperty
  a_strobe_period: assert property (p_strobe_period) else $error("comparator strobe spacing wrong"); // RL12

  property p_eight_decisions;
    @(posedge clock_i) disable iff (rst_i)
      conv.done |-> strobe_cnt == 4'h8;
  endproperty
  a_eight_decisions: assert property (p_eight_decisions) else $error("result without eight decisions"); // RL10

  property p_zero_when_below;
    @(posedge clock_i) disable iff (rst_i)
      conv.done && !comp_seen |-> conv.result == 8'h00;
  endproperty
  a_zero_when_below: assert property (p_zero_when_below) else $error("nonzero code for low input"); // RL15
endmodule
`default_nettype wire

// >>> core/adcm_top.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RL1: Four-input differential pairs are 1/2, 3/4.
// RL2: Address bit picks polarity within pair.
// RL3: Single-ended: channel positive, analog ground negative.
// RL4: Four-input pseudo: inputs 1-3 against input 4.
// RL5: Eight inputs support all three modes.
// RL6: Eight-input differential: pair and polarity from address.
// RL7: Eight-input single-ended: channel 1-8 against ground.
// RL8: Eight-input pseudo: channel 1-7 against channel 8.
// RL9: Read low during write keeps old configuration.
// RL10: Result is eight bits, 256 codes.
// RL11: Positive sampled, negative half period later.
// RL12: Comparator strobed at end of each period.
// RL13: Code encodes difference; equal inputs give zero.
// RL14: Write rise with read high latches address, starts.
// RL15: Positive below negative gives all-zeros code.
// RL16: Done latches result, interrupt low; read releases.
// RL17: Write fall releases interrupt, readies new conversion.
// RL18: Configuration persists until next address load.
module adcm_top #(
  parameter int unsigned HALF_CYCLES = adcm_pkg::HALF_CYCLES
) (
  input  wire logic                clock_i,
  input  wire logic                rst_i,
  input  wire logic                cs_n_i,
  input  wire logic                wr_n_i,
  input  wire logic                rd_n_i,
  input  wire logic [7:0]          db_i,
  input  wire logic                comparator_i,
  input  wire logic                eight_input_variant_i,
  output logic [7:0]               db_o,
  output logic                     db_oe_o,
  output logic                     conversion_done_irq_n_o,
  output logic [7:0]               pos_sel_o,
  output logic [7:0]               neg_sel_o,
  output logic                     analog_ground_pin_o,
  output adcm_pkg::adcm_mode_t     mux_mode_o,
  output logic [7:0]               dac_code_o,
  output logic                     sample_pos_o,
  output logic                     sample_neg_o,
  output logic                     comp_strobe_o,
  output logic                     busy_o
);
  localparam int CONV_BOUND = adcm_pkg::CONV_MAX_CYCLES;

  adcm_conv_if conv ();

  logic [12:0]                sync_a;
  logic [12:0]                sync_b;
  logic                       cs_n_s;
  logic                       wr_n_s;
  logic                       rd_n_s;
  logic                       comp_s;
  logic                       eight_s;
  logic [7:0]                 db_s;
  logic                       wr_n_prev;
  logic                       in_write;
  logic                       wr_fall;
  logic                       wr_rise;
  logic                       addr_load;
  logic                       read_now;
  logic [4:0]                 mux_addr;
  logic [7:0]                 next_pos_sel;
  logic [7:0]                 next_neg_sel;
  logic                       next_analog_ground_pin;
  adcm_pkg::adcm_mode_t       next_mode;

  // Every pin crosses two flops before use
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sync_a <= adcm_pkg::SYNC_RST;
      sync_b <= adcm_pkg::SYNC_RST;
    end else begin
      sync_a <= {cs_n_i, wr_n_i, rd_n_i, comparator_i, eight_input_variant_i, db_i};
      sync_b <= sync_a;
    end
  end

  assign cs_n_s  = sync_b[adcm_pkg::SYNC_CS_POS];
  assign wr_n_s  = sync_b[adcm_pkg::SYNC_WR_POS];
  assign rd_n_s  = sync_b[adcm_pkg::SYNC_RD_POS];
  assign comp_s  = sync_b[adcm_pkg::SYNC_CMP_POS];
  assign eight_s = sync_b[adcm_pkg::SYNC_VAR_POS];
  assign db_s    = sync_b[7:0];

  // Strobe decode; address and strobes share the same sync delay
  assign wr_fall   = wr_n_prev && !wr_n_s && !cs_n_s;
  assign wr_rise   = in_write && !wr_n_prev && wr_n_s && !cs_n_s;
  assign addr_load = wr_rise && rd_n_s;                         // RL14
  assign read_now  = !cs_n_s && !rd_n_s && wr_n_s;

  assign conv.start = wr_rise;                                  // RL14
  assign conv.abort = wr_fall;                                  // RL17
  assign busy_o     = conv.busy;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wr_n_prev <= 1'b1;
      in_write  <= 1'b0;
    end else begin
      wr_n_prev <= wr_n_s;
      if (wr_fall) begin
        in_write <= 1'b1;
      end else if (wr_n_s) begin
        in_write <= 1'b0;
      end
    end
  end

  // Read held low at the rising write edge leaves the old setting
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mux_addr <= adcm_pkg::MUX_ADDR_RST;
    end else if (addr_load) begin
      mux_addr <= db_s[4:0];                                    // RL9 RL18
    end
  end

  adcm_mux_decode u_decode (
    .addr_i     (mux_addr),
    .eight_i    (eight_s),
    .pos_sel_o  (next_pos_sel),
    .neg_sel_o  (next_neg_sel),
    .analog_ground_pin_sel_o (next_analog_ground_pin),
    .mode_o     (next_mode)
  );

  // Switch selects are registered so the analog mux never sees glitches
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pos_sel_o           <= 8'h00;
      neg_sel_o           <= 8'h00;
      analog_ground_pin_o <= 1'b0;
      mux_mode_o          <= adcm_pkg::MODE_SINGLE;
    end else begin
      pos_sel_o           <= next_pos_sel;
      neg_sel_o           <= next_neg_sel;
      analog_ground_pin_o <= next_analog_ground_pin;
      mux_mode_o          <= next_mode;
    end
  end

  adcm_sar_seq #(
    .HALF (HALF_CYCLES)
  ) u_seq (
    .clock_i       (clock_i),
    .rst_i         (rst_i),
    .conv          (conv.seq),
    .comp_i        (comp_s),
    .dac_code_o    (dac_code_o),
    .sample_pos_o  (sample_pos_o),
    .sample_neg_o  (sample_neg_o),
    .comp_strobe_o (comp_strobe_o)
  );

  // Completion wins over a release in the same cycle
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      conversion_done_irq_n_o <= 1'b1;
    end else if (conv.done) begin
      conversion_done_irq_n_o <= 1'b0;                          // RL16
    end else if (wr_fall || read_now) begin
      conversion_done_irq_n_o <= 1'b1;                          // RL16 RL17
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      db_o    <= adcm_pkg::RESULT_RST;
      db_oe_o <= 1'b0;
    end else begin
      if (conv.done) begin
        db_o <= conv.result;                                    // RL16
      end
      db_oe_o <= !cs_n_s && !rd_n_s;                            // RL16
    end
  end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  property p_diff4;
    !eight_s && !mux_addr[adcm_pkg::MUX_CFG_POS]
      |=> (pos_sel_o | neg_sel_o) == ($past(mux_addr[1]) ? 8'h0c : 8'h03);
  endproperty
  a_diff4: assert property (p_diff4) else $error("four-input pair wrong"); // RL1

  property p_polarity4;
    !eight_s && !mux_addr[adcm_pkg::MUX_CFG_POS]
      |=> pos_sel_o == adcm_pkg::chan_onehot({1'b0, $past(mux_addr[1:0])});
  endproperty
  a_polarity4: assert property (p_polarity4) else $error("pair polarity wrong"); // RL2

  property p_single4;
    !eight_s && mux_addr[4:3] == 2'b01
      |=> analog_ground_pin_o && neg_sel_o == 8'h00
          && pos_sel_o == adcm_pkg::chan_onehot({1'b0, $past(mux_addr[1:0])});
  endproperty
  a_single4: assert property (p_single4) else $error("four-input single-ended wrong"); // RL3

  property p_pseudo4;
    !eight_s && mux_addr[4:3] == 2'b11
      |=> neg_sel_o == 8'h08 && pos_sel_o != 8'h00 && (pos_sel_o & 8'hf8) == 8'h00;
  endproperty
  a_pseudo4: assert property (p_pseudo4) else $error("four-input pseudo wrong"); // RL4

  property p_modes;
    1'b1 |=> mux_mode_o == (!$past(mux_addr[3]) ? adcm_pkg::MODE_DIFF
             : !$past(mux_addr[4]) ? adcm_pkg::MODE_SINGLE : adcm_pkg::MODE_PSEUDO);
  endproperty
  a_modes: assert property (p_modes) else $error("mode decode wrong"); // RL5

  property p_diff8;
    eight_s && !mux_addr[adcm_pkg::MUX_CFG_POS]
      |=> pos_sel_o == adcm_pkg::chan_onehot($past(mux_addr[2:0]))
          && neg_sel_o == adcm_pkg::chan_onehot($past(mux_addr[2:0]) ^ 3'h1);
  endproperty
  a_diff8: assert property (p_diff8) else $error("eight-input differential wrong"); // RL6

  property p_single8;
    eight_s && mux_addr[4:3] == 2'b01
      |=> analog_ground_pin_o && neg_sel_o == 8'h00
          && pos_sel_o == adcm_pkg::chan_onehot($past(mux_addr[2:0]));
  endproperty
  a_single8: assert property (p_single8) else $error("eight-input single-ended wrong"); // RL7

  property p_pseudo8;
    eight_s && mux_addr[4:3] == 2'b11 && mux_addr[2:0] != 3'h7
      |=> neg_sel_o == 8'h80 && pos_sel_o == adcm_pkg::chan_onehot($past(mux_addr[2:0]));
  endproperty
  a_pseudo8: assert property (p_pseudo8) else $error("eight-input pseudo wrong"); // RL8

  property p_keep_on_read;
    wr_rise && !rd_n_s |=> mux_addr == $past(mux_addr) && busy_o;
  endproperty
  a_keep_on_read: assert property (p_keep_on_read) else $error("configuration changed on read"); // RL9

  property p_load_start;
    wr_rise && rd_n_s |=> mux_addr == $past(db_s[4:0]) && busy_o;
  endproperty
  a_load_start: assert property (p_load_start) else $error("address not latched or no start"); // RL14

  property p_done_bound;
    conv.start |-> ##[1:CONV_BOUND] (conv.done || conv.abort || conv.start);
  endproperty
  a_done_bound: assert property (p_done_bound) else $error("conversion exceeded limit"); // RL16

  property p_done_irq;
    conv.done |=> !conversion_done_irq_n_o && db_o == $past(conv.result);
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("done did not latch result"); // RL16

  property p_read_release;
    read_now && !conv.done |=> conversion_done_irq_n_o && db_oe_o;
  endproperty
  a_read_release: assert property (p_read_release) else $error("read did not release"); // RL16

  property p_write_fall;
    wr_fall && !conv.done |=> conversion_done_irq_n_o && !busy_o;
  endproperty
  a_write_fall: assert property (p_write_fall) else $error("write fall did not reset"); // RL17

  property p_persist;
    !addr_load |=> $stable(mux_addr);
  endproperty
  a_persist: assert property (p_persist) else $error("configuration drifted"); // RL18

  // Data bus enable follows the synced strobes with one flop of delay
  property p_oe_follows;
    1'b1 |=> db_oe_o == !($past(cs_n_s) || $past(rd_n_s));
  endproperty
  a_oe_follows: assert property (p_oe_follows) else $error("bus enable wrong"); // RL16

  property p_irq_holds;
    !conversion_done_irq_n_o && !wr_fall && !read_now |=> !conversion_done_irq_n_o;
  endproperty
  a_irq_holds: assert property (p_irq_holds) else $error("interrupt dropped early"); // RL16

  property p_result_stands;
    !conv.done |=> $stable(db_o);
  endproperty
  a_result_stands: assert property (p_result_stands) else $error("result latch moved"); // RL16

  property p_one_positive;
    1'b1 |=> $onehot(pos_sel_o) && (analog_ground_pin_o == (neg_sel_o == 8'h00));
  endproperty
  a_one_positive: assert property (p_one_positive) else $error("select pattern wrong"); // RL3

  property p_start_on_write;
    !wr_rise |=> !$rose(busy_o);
  endproperty
  a_start_on_write: assert property (p_start_on_write) else $error("start without write"); // RL14

  property p_done_idle;
    conv.done |-> !busy_o;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("busy after done"); // RL16

endmodule
`default_nettype wire

// >>> verif/adcm_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcm_cpu_model (
  input  wire logic [7:0] pos_sel_i,
  input  wire logic [7:0] neg_sel_i,
  input  wire logic [7:0] dac_i,
  input  wire logic [7:0] db_i,
  input  wire logic       oe_i,
  input  wire logic       clock_i,
  output logic            cs_n_o,
  output logic            wr_n_o,
  output logic            rd_n_o,
  output logic [7:0]      db_o,
  output logic            comp_o
);
  int unsigned vin [8];
  int          vp;
  int          vn;

  initial begin
    cs_n_o = 1'b1;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    db_o   = 8'h00;
  end

  // Ground reference reads as zero volts
  always_comb begin
    vp = 0;
    vn = 0;
    for (int k = 0; k < 8; k++) begin
      if (pos_sel_i[k]) vp = vin[k];
      if (neg_sel_i[k]) vn = vin[k];
    end
    comp_o = (vp - vn) >= int'(dac_i);
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic write_fall(input logic [7:0] a, input logic keep);
    cs_n_o <= 1'b0;
    wr_n_o <= 1'b0;
    rd_n_o <= ~keep;
    db_o   <= a;
    wait_clk(4);
  endtask

  // Data held well past the rise, since pins pass two sync flops
  task automatic write_rise();
    wr_n_o <= 1'b1;
    wait_clk(4);
    cs_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    db_o   <= ~db_o;
    wait_clk(2);
  endtask

  task automatic read(output logic [7:0] d, output logic oe);
    cs_n_o <= 1'b0;
    rd_n_o <= 1'b0;
    wait_clk(4);
    d = db_i;
    oe = oe_i;
    cs_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    wait_clk(4);
  endtask
endmodule
`default_nettype wire

// >>> verif/adcm_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adcm_top_tb;
  localparam int HALF = 4;
  logic                 clock_i = 1'b0;
  logic                 rst_i = 1'b1;
  logic                 eight = 1'b0;
  logic                 cs_n, wr_n, rd_n, comp, oe, irq_n, analog_ground_pin;
  logic                 smp_p, smp_n, strobe, busy;
  logic [7:0]           db_w, db_r, pos, neg, dac;
  adcm_pkg::adcm_mode_t mode;
  int                   failures = 0;
  int                   checks = 0;
  int                   cyc = 0;
  int                   pcnt, gap, nstr, cur;

  always #20 clock_i = ~clock_i;

  adcm_top #(.HALF_CYCLES(HALF)) u_dut (
    .clock_i(clock_i), .rst_i(rst_i), .cs_n_i(cs_n), .wr_n_i(wr_n),
    .rd_n_i(rd_n), .db_i(db_w), .comparator_i(comp),
    .eight_input_variant_i(eight), .db_o(db_r), .db_oe_o(oe),
    .conversion_done_irq_n_o(irq_n), .pos_sel_o(pos), .neg_sel_o(neg),
    .analog_ground_pin_o(analog_ground_pin), .mux_mode_o(mode), .dac_code_o(dac),
    .sample_pos_o(smp_p), .sample_neg_o(smp_n), .comp_strobe_o(strobe),
    .busy_o(busy));

  adcm_cpu_model u_cpu (
    .pos_sel_i(pos), .neg_sel_i(neg), .dac_i(dac), .db_i(db_r), .oe_i(oe),
    .clock_i(clock_i), .cs_n_o(cs_n), .wr_n_o(wr_n), .rd_n_o(rd_n),
    .db_o(db_w), .comp_o(comp));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Gap from positive to negative sample, strobes per conversion
  always @(posedge clock_i) begin
    cyc++;
    pcnt <= smp_p ? 0 : pcnt + 1;
    if (smp_n) gap <= pcnt + 1;
    if (smp_p) nstr <= 0;
    else if (strobe) nstr <= nstr + 1;
    if (cyc == 30000) begin
      failures++;
      stop_test();
    end
  end

  // Channel indices 0..7; negative -1 means analog ground
  function automatic void model(input int a, input bit e8, output int p, output int n,
                                output int m);
    int lo;
    lo = e8 ? a & 7 : a & 3;
    if ((a & 8) == 0) begin
      m = 1;
      p = a & (e8 ? 6 : 2);
      n = p + 1;
      if (a & 1) begin
        n = p;
        p = p + 1;
      end
    end else if ((a & 16) == 0) begin
      m = 2;
      p = lo;
      n = -1;
    end else begin
      m = 4;
      n = e8 ? 7 : 3;
      p = (lo == n) ? lo - 1 : lo;
    end
  endfunction

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq_n !== 1'b0 && n < adcm_pkg::CONV_MAX_CYCLES) begin
      @(posedge clock_i);
      n++;
    end
    check("irq_low", irq_n, 0);
  endtask

  task automatic run(input int a, input bit keep, input bit e8, input bit rd_back,
                     input bit wt);
    int p, n, m, vp, vn, r;
    logic [7:0] d;
    logic o;
    eight <= e8;
    if (!keep) cur = a;
    model(cur, e8, p, n, m);
    r = $urandom % 256;
    for (int k = 0; k < 8; k++) u_cpu.vin[k] <= (a % 4 == 0) ? r : $urandom % 256;
    u_cpu.write_fall(8'(a), keep);
    check("irq_fall", irq_n, 1);
    u_cpu.write_rise();
    check("pos_sel", pos, 32'h1 << p);
    check("neg_sel", neg, n < 0 ? 0 : 32'h1 << n);
    check("analog_ground_pin", analog_ground_pin, n < 0);
    check("mode", mode, m);
    check("busy", busy, 1);
    if (!wt) return;
    wait_irq();
    check("idle", busy, 0);
    vp = u_cpu.vin[p];
    vn = n < 0 ? 0 : u_cpu.vin[n];
    check("result", db_r, vp < vn ? 0 : vp - vn);
    check("strobes", nstr, 8);
    check("gap", gap, HALF);
    if (rd_back) begin
      u_cpu.read(d, o);
      check("rd_data", d, vp < vn ? 0 : vp - vn);
      check("rd_oe", o, 1);
      check("irq_rel", irq_n, 1);
    end
  endtask

  initial begin
    void'($urandom(25));
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    check("irq_rst", irq_n, 1);
    check("oe_rst", oe, 0);
    check("mode_rst", mode, adcm_pkg::MODE_SINGLE);
    $display("test reset done");
    // Odd runs skip the read so the next write fall must release the interrupt
    for (int i = 0; i < 64; i++) run(i % 32, 0, i / 32, i % 2 == 0, i % 8 != 7);
    $display("test decode done");
    for (int i = 0; i < 16; i++) run($urandom % 32, i % 2, 1, 1, 1);
    $display("test keep done");
    stop_test();
  end
endmodule
`default_nettype wire
